// File: logic/rpmc_pkg.sv
/*
  Shared constants and types for the retimer power and mode control block.
  Assumes one 25 MHz clock and registers reached over the two-wire control bus.
*/
package rpmc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_POWER = 8'h09;
  localparam logic [7:0] REG_RATIO = 8'h0A;
  localparam logic [7:0] REG_TERM  = 8'h0B;
  localparam logic [7:0] REG_SWING = 8'h0C;
  localparam logic [7:0] RST_POWER = 8'h00;
  localparam logic [7:0] RST_RATIO = 8'h00;
  localparam logic [7:0] RST_TERM  = 8'h00;
  localparam logic [7:0] RST_SWING = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;

  // Field positions
  localparam int RETIMER_BIT = 0;
  localparam int SWAP_BIT    = 1;
  localparam int PD_BIT      = 3;
  localparam int RATIO_BIT   = 0;
  localparam int EMPH_LSB    = 0;
  localparam int SWING_LSB   = 2;
  localparam int TERM_LSB    = 3;
  localparam int SLEW_LSB    = 6;

  // Strap codes
  localparam logic [1:0] EMPH_M2DB   = 2'h1;
  localparam logic [1:0] EMPH_MID    = 2'h0;
  localparam logic [1:0] EMPH_HIGH   = 2'h2;
  localparam logic [1:0] CODE_ZERO   = 2'h0;
  localparam logic [1:0] CODE_MAX    = 2'h3;
  localparam logic [1:0] SLEW_REC    = 2'h2;
  localparam logic [5:0] SWING_NOM   = 6'h00;

  // Bus framing
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] PTR_STEP  = 8'h01;

  // Synchroniser lanes
  localparam int SY_OE    = 0;
  localparam int SY_HPD   = 1;
  localparam int SY_SCL   = 2;
  localparam int SY_SDA   = 3;
  localparam int SY_SD    = 4;
  localparam int SY_PINS  = 5;
  localparam int SY_STRAP = 6;
  localparam int SYNC_W   = 14;
  localparam int ST_EMPH  = 0;
  localparam int ST_TERM  = 1;
  localparam int ST_SLEW  = 2;
  localparam int ST_EQ    = 3;

  typedef enum {LVL_LOW, LVL_MID, LVL_HIGH} rpmc_level_t;
  typedef enum {PS_OFF, PS_HPD_DOWN, PS_SW_DOWN, PS_ACTIVE} rpmc_pstate_t;
  typedef enum {BS_IDLE, BS_ADDR, BS_REG, BS_WDATA, BS_ACK, BS_RDATA, BS_RACK} rpmc_bstate_t;

  typedef struct packed {
    logic [7:0] pwr;
    logic [7:0] ratio;
    logic [7:0] term;
    logic [7:0] swing;
  } rpmc_regs_t;

  localparam rpmc_regs_t RST_REGS = '{RST_POWER, RST_RATIO, RST_TERM, RST_SWING};

  typedef struct packed {
    logic rx;
    logic tx;
    logic cdr;
    logic ddc;
    logic aux;
    logic bus;
  } rpmc_en_t;

  typedef struct packed {
    logic [1:0] emphasis;
    logic [5:0] swing;
    logic [1:0] term;
    logic       term_auto;
    logic [1:0] slew;
    logic       eq_fixed;
    logic       lane_swap;
    logic       retimer;
  } rpmc_cfg_t;

endpackage

// File: logic/rpmc_power_mode_control.sv
/*
  Power state, hot-plug pass-through, control-bus register slave and
  transmitter tuning for the retimer.
  Assumes pins arrive asynchronously, the bus master keeps bus timing
  slow against the 40 ns clock, and straps arrive as pull-up/pull-down
  sense pairs per pin.
*/
`timescale 1ns/100ps

// Contract
// - Enable low: all enables off, bus released
// - Enable rising edge restores all defaults
// - Enable low clears all bus registers
// - Sink hot-plug low keeps power-down, bus alive
// - Power-down bit forces power-down, bus alive
// - Source hot-plug follows sink hot-plug always
// - Recovery and outputs follow signal detector
// - Both high, no power-down: full operation
// - Clock-ratio flag cleared in power-down
// - Emphasis field lives in 0Ch bits 1:0
// - Edge-rate field lives in 0Bh bits 7:6
// - Swing field lives in 0Ch bits 7:2
// - Straps decode high, low, mid
// - Strap low emphasis -2 dB, mid auto term
// - Selectable main-lane input swap
// - Equalizer adaptive unless pin selects fixed
module rpmc_power_mode_control #(
  parameter logic [6:0] DEV_ADDR = 7'h2C  // arbitrary bus address
) (
  input  wire logic              sys_clk_in,
  input  wire logic              reset_in,
  input  wire logic              output_enable_in,
  input  wire logic              sink_hotplug_in,
  input  wire logic              signal_detect_in,
  input  wire logic              strap_mode_in,
  input  wire logic [7:0]        strap_sense_in,
  input  wire logic              control_bus_clock_in,
  input  wire logic              control_bus_data_in,
  output logic                   control_bus_data_out,
  output logic                   control_bus_data_oe_out,
  output logic                   source_hotplug_out,
  output logic                   power_down_out,
  output rpmc_pkg::rpmc_en_t     enables_out,
  output rpmc_pkg::rpmc_cfg_t    cfg_out
);
  import rpmc_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] s1;
  logic [SYNC_W-1:0] s2;
  logic [SYNC_W-1:0] s3;
  logic [SYNC_W-1:0] filt;
  logic [SYNC_W-1:0] next_filt;

  // Concatenate all slow pins into one lane vector
  assign raw = {strap_sense_in, strap_mode_in, signal_detect_in,
                control_bus_data_in, control_bus_clock_in,
                sink_hotplug_in, output_enable_in};

  // Three stages; a lane moves only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_sync
      assign next_filt[g] = (s2[g] == s3[g]) ? s3[g] : filt[g];
      always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
          s1[g]   <= 1'b0;
          s2[g]   <= 1'b0;
          s3[g]   <= 1'b0;
          filt[g] <= 1'b0;
        end else begin
          s1[g]   <= raw[g];
          s2[g]   <= s1[g];
          s3[g]   <= s2[g];
          filt[g] <= next_filt[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  logic oe_d;
  logic scl_d;
  logic sda_d;
  logic oe_rise;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic clr;

  // Delayed copies; reset matches the filter reset, so no false edge
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      oe_d  <= 1'b0;
      scl_d <= 1'b0;
      sda_d <= 1'b0;
    end else begin
      oe_d  <= filt[SY_OE];
      scl_d <= filt[SY_SCL];
      sda_d <= filt[SY_SDA];
    end
  end

  // One pulse per filtered edge; the filter blocks chatter
  assign oe_rise  = filt[SY_OE] & ~oe_d;
  assign clr      = ~filt[SY_OE] | oe_rise;
  assign scl_rise = filt[SY_SCL] & ~scl_d;
  assign scl_fall = ~filt[SY_SCL] & scl_d;
  assign start    = filt[SY_SCL] & scl_d & sda_d & ~filt[SY_SDA];
  assign stop     = filt[SY_SCL] & scl_d & ~sda_d & filt[SY_SDA];

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  rpmc_pstate_t pst;
  rpmc_pstate_t next_pst;
  rpmc_en_t     next_en;
  rpmc_regs_t   rg;

  // Priority: enable pin, then sink hot-plug, then software bit
  always_comb begin
    if (!filt[SY_OE]) begin
      next_pst = PS_OFF;
    end else if (!filt[SY_HPD]) begin
      next_pst = PS_HPD_DOWN;
    end else if (rg.pwr[PD_BIT]) begin
      next_pst = PS_SW_DOWN;
    end else begin
      next_pst = PS_ACTIVE;
    end
    next_en = '0;
    case (next_pst)
      PS_OFF: begin
        next_en = '0;
      end
      PS_HPD_DOWN, PS_SW_DOWN: begin
        next_en.bus = 1'b1;
      end
      PS_ACTIVE: begin
        next_en.rx  = 1'b1;
        next_en.ddc = 1'b1;
        next_en.aux = 1'b1;
        next_en.bus = 1'b1;
        next_en.cdr = filt[SY_SD];
        next_en.tx  = filt[SY_SD];
      end
      default: begin
        next_en = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pst         <= PS_OFF;
      enables_out <= '0;
    end else begin
      pst         <= next_pst;
      enables_out <= next_en;
    end
  end

  assign power_down_out     = (pst != PS_ACTIVE);
  assign source_hotplug_out = filt[SY_HPD];

  // ----------------------------------------------------------------
  // Control-bus slave and registers
  // ----------------------------------------------------------------
  rpmc_bstate_t bst;
  rpmc_bstate_t next_bst;
  rpmc_bstate_t ack_to;
  rpmc_bstate_t next_ack_to;
  logic [3:0]   cnt;
  logic [3:0]   next_cnt;
  logic [7:0]   sh;
  logic [7:0]   next_sh;
  logic [7:0]   ptr;
  logic [7:0]   next_ptr;
  rpmc_regs_t   next_rg;

  // Unmapped offsets read as zero and drop writes
  function automatic logic [7:0] rd(input rpmc_regs_t r, input logic [7:0] a);
    case (a)
      REG_POWER: rd = r.pwr;
      REG_RATIO: rd = r.ratio;
      REG_TERM:  rd = r.term;
      REG_SWING: rd = r.swing;
      default:   rd = READ_NONE;
    endcase
  endfunction

  function automatic rpmc_regs_t wr(input rpmc_regs_t r, input logic [7:0] a,
                                    input logic [7:0] d);
    wr = r;
    case (a)
      REG_POWER: wr.pwr = d;
      REG_RATIO: wr.ratio = d;
      REG_TERM:  wr.term = d;
      REG_SWING: wr.swing = d;
      default:   wr = r;
    endcase
  endfunction

  // Byte engine; pointer auto-increments across a burst
  always_comb begin
    next_bst    = bst;
    next_ack_to = ack_to;
    next_cnt    = cnt;
    next_sh     = sh;
    next_ptr    = ptr;
    next_rg     = rg;
    if (start) begin
      next_bst = BS_ADDR;
      next_cnt = '0;
    end else if (stop) begin
      next_bst = BS_IDLE;
    end else if (scl_rise) begin
      case (bst)
        BS_ADDR, BS_REG, BS_WDATA: begin
          next_sh  = {sh[6:0], filt[SY_SDA]};
          next_cnt = cnt + 4'h1;
        end
        BS_RDATA: next_cnt = cnt + 4'h1;
        BS_RACK: if (filt[SY_SDA]) next_bst = BS_IDLE;
        default: next_bst = bst;
      endcase
    end else if (scl_fall && cnt == BYTE_BITS) begin
      next_cnt = '0;
      case (bst)
        BS_ADDR: begin
          next_bst    = (sh[7:1] == DEV_ADDR) ? BS_ACK : BS_IDLE;
          next_ack_to = sh[0] ? BS_RDATA : BS_REG;
        end
        BS_REG: begin
          next_ptr    = sh;
          next_bst    = BS_ACK;
          next_ack_to = BS_WDATA;
        end
        BS_WDATA: begin
          next_rg  = wr(rg, ptr, sh);
          next_ptr = ptr + PTR_STEP;
          next_bst = BS_ACK;
        end
        BS_RDATA: next_bst = BS_RACK;
        default: next_bst = bst;
      endcase
    end else if (scl_fall) begin
      case (bst)
        BS_ACK, BS_RACK: begin
          next_bst = ack_to;
          next_cnt = '0;
          if (ack_to == BS_RDATA) begin
            next_sh  = rd(rg, ptr);
            next_ptr = ptr + PTR_STEP;
          end
        end
        BS_RDATA: next_sh = {sh[6:0], 1'b0};
        default: next_bst = bst;
      endcase
    end
    // Hardware clear beats a bus write landing in the same cycle
    if (pst != PS_ACTIVE) begin
      next_rg.ratio[RATIO_BIT] = 1'b0;
    end
    if (clr) begin
      next_rg  = RST_REGS;
      next_bst = BS_IDLE;
      next_cnt = '0;
      next_ptr = '0;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      bst    <= BS_IDLE;
      ack_to <= BS_IDLE;
      cnt    <= '0;
      sh     <= '0;
      ptr    <= '0;
      rg     <= RST_REGS;
    end else begin
      bst    <= next_bst;
      ack_to <= next_ack_to;
      cnt    <= next_cnt;
      sh     <= next_sh;
      ptr    <= next_ptr;
      rg     <= next_rg;
    end
  end

  // Open-drain data: only ever pulls low, never while disabled
  assign control_bus_data_out    = 1'b0;
  assign control_bus_data_oe_out = enables_out.bus &
                                   ((bst == BS_ACK) | ((bst == BS_RDATA) & ~sh[7]));

  // ----------------------------------------------------------------
  // Transmitter tuning
  // ----------------------------------------------------------------
  rpmc_cfg_t   next_cfg;
  rpmc_level_t lv_emph;
  rpmc_level_t lv_term;
  rpmc_level_t lv_slew;
  rpmc_level_t lv_eq;

  // Pull-up sensed alone is high, pull-down alone low, else mid
  function automatic rpmc_level_t lvl(input logic [1:0] s);
    case (s)
      2'b10:   lvl = LVL_HIGH;
      2'b01:   lvl = LVL_LOW;
      default: lvl = LVL_MID;
    endcase
  endfunction

  assign lv_emph = lvl(filt[SY_STRAP+2*ST_EMPH +: 2]);
  assign lv_term = lvl(filt[SY_STRAP+2*ST_TERM +: 2]);
  assign lv_slew = lvl(filt[SY_STRAP+2*ST_SLEW +: 2]);
  assign lv_eq   = lvl(filt[SY_STRAP+2*ST_EQ +: 2]);

  // Strap mode suits hosts without a bus; it gives coarser tuning
  always_comb begin
    next_cfg           = '0;
    next_cfg.lane_swap = rg.pwr[SWAP_BIT];
    next_cfg.retimer   = rg.pwr[RETIMER_BIT];
    next_cfg.eq_fixed  = (lv_eq != LVL_MID);
    if (filt[SY_PINS]) begin
      case (lv_emph)
        LVL_LOW:  next_cfg.emphasis = EMPH_M2DB;
        LVL_HIGH: next_cfg.emphasis = EMPH_HIGH;
        default:  next_cfg.emphasis = EMPH_MID;
      endcase
      next_cfg.term_auto = (lv_term == LVL_MID);
      next_cfg.term      = (lv_term == LVL_HIGH) ? CODE_MAX : CODE_ZERO;
      case (lv_slew)
        LVL_LOW:  next_cfg.slew = CODE_ZERO;
        LVL_HIGH: next_cfg.slew = CODE_MAX;
        default:  next_cfg.slew = SLEW_REC;
      endcase
      next_cfg.swing = SWING_NOM;
    end else begin
      next_cfg.emphasis = rg.swing[EMPH_LSB +: 2];
      next_cfg.swing    = rg.swing[SWING_LSB +: 6];
      next_cfg.term     = rg.term[TERM_LSB +: 2];
      next_cfg.slew     = rg.term[SLEW_LSB +: 2];
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cfg_out <= '0;
    end else begin
      cfg_out <= next_cfg;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  sequence oe_rising_s;
    !filt[SY_OE] ##1 filt[SY_OE];
  endsequence

  sequence regs_default_s;
    rg == RST_REGS && bst == BS_IDLE;
  endsequence

  off_bus_released_a: assert property (
    pst == PS_OFF |-> !control_bus_data_oe_out && enables_out == '0)
    else $error("Disabled device still drives");
  oe_rise_reset_a: assert property (oe_rising_s |=> regs_default_s)
    else $error("Enable edge did not restore defaults");
  oe_low_clear_a: assert property (!filt[SY_OE] |=> regs_default_s)
    else $error("Registers kept while disabled");
  hpd_down_a: assert property (
    filt[SY_OE] && !filt[SY_HPD] |=> pst == PS_HPD_DOWN && enables_out.bus
    && !enables_out.tx && !enables_out.ddc)
    else $error("Sink unplugged but not powered down");
  sw_down_a: assert property (
    filt[SY_OE] && filt[SY_HPD] && rg.pwr[PD_BIT] |=> pst == PS_SW_DOWN
    && enables_out.bus && !enables_out.rx)
    else $error("Software power-down ignored");
  hotplug_follow_a: assert property (
    s2[SY_HPD] && s3[SY_HPD] |=> source_hotplug_out)
    else $error("Source hot-plug does not follow sink");
  cdr_gate_a: assert property (
    enables_out.cdr |-> pst == PS_ACTIVE && $past(filt[SY_SD]))
    else $error("Recovery on without signal");
  active_full_a: assert property (
    pst == PS_ACTIVE |-> enables_out.rx && enables_out.ddc && enables_out.aux)
    else $error("Active state missing a path");
  ratio_clear_a: assert property (pst != PS_ACTIVE |=> !rg.ratio[RATIO_BIT])
    else $error("Clock-ratio flag survived power-down");
  reset_pulse_a: assert property (oe_rise |=> !oe_rise)
    else $error("Enable edge pulse too long");
  swing_map_a: assert property (
    !filt[SY_PINS] |=> cfg_out.emphasis == $past(rg.swing[EMPH_LSB +: 2])
    && cfg_out.swing == $past(rg.swing[SWING_LSB +: 6]))
    else $error("Swing register not applied");
  term_map_a: assert property (
    !filt[SY_PINS] |=> cfg_out.term == $past(rg.term[TERM_LSB +: 2])
    && cfg_out.slew == $past(rg.term[SLEW_LSB +: 2]))
    else $error("Termination register not applied");
  strap_emph_a: assert property (
    filt[SY_PINS] && lv_emph == LVL_LOW |=> cfg_out.emphasis == EMPH_M2DB)
    else $error("Low emphasis strap misdecoded");

endmodule

// File: test/rpmc_bus_host.sv
/*
  Model of the graphics source that programs the retimer over the two-wire bus.
  Assumes the bench resolves the open-drain data wire with a pull-up and
  that the 40 ns system clock is used only to pace the bus.
*/
`timescale 1ns/100ps

module rpmc_bus_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2C,  // Arbitrary, must match the device
  parameter int         QTR      = 8       // Quarter bit in clocks, bit time 32
) (
  input  wire logic clk_in,
  input  wire logic data_in,
  output logic      clock_out,
  output logic      data_low_out
);

  // Bus idles released: clock high, data left to the pull-up
  initial begin
    clock_out    = 1'b1;
    data_low_out = 1'b0;
  end

  task automatic wait_q();
    repeat (QTR) @(posedge clk_in);
  endtask

  // Start, or repeated start from a low clock
  task automatic start_cond();
    data_low_out <= 1'b0;
    wait_q();
    clock_out <= 1'b1;
    wait_q();
    data_low_out <= 1'b1;
    wait_q();
    clock_out <= 1'b0;
    wait_q();
  endtask

  task automatic stop_cond();
    data_low_out <= 1'b1;
    wait_q();
    clock_out <= 1'b1;
    wait_q();
    data_low_out <= 1'b0;
    wait_q();
  endtask

  // Data moves only while clock is low, a quarter bit after the fall
  task automatic xfer_bit(input logic bit_val, output logic seen);
    data_low_out <= ~bit_val;
    wait_q();
    clock_out <= 1'b1;
    wait_q();
    seen = data_in;
    wait_q();
    clock_out <= 1'b0;
    wait_q();
  endtask

  // Sending ones releases the wire, so a read is the same loop
  task automatic xfer_byte(input logic [7:0] tx, input logic ack_bit,
                           output logic [7:0] rx, output logic acked);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(tx[i], seen);
      rx[i] = seen;
    end
    xfer_bit(ack_bit, seen);
    acked = ~seen;
  endtask

  task automatic write_reg(input logic [7:0] off, input logic [7:0] dat,
                           output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    start_cond();
    xfer_byte({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
    xfer_byte(off, 1'b1, rx, a1);
    xfer_byte(dat, 1'b1, rx, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

  // Ends the single data byte with a not-acknowledge
  task automatic read_reg(input logic [7:0] off, output logic [7:0] dat,
                          output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       a3;
    start_cond();
    xfer_byte({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
    xfer_byte(off, 1'b1, rx, a1);
    start_cond();
    xfer_byte({DEV_ADDR, 1'b1}, 1'b1, rx, a2);
    xfer_byte(8'hFF, 1'b1, dat, a3);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

endmodule

// File: test/rpmc_power_mode_control_tb.sv
/*
  Self-checking bench for the retimer power and mode control block.
  Assumes the bus host model paces the two-wire bus; the data wire is
  resolved here from both open-drain drivers with a pull-up.
*/
`timescale 1ns/100ps

module rpmc_power_mode_control_tb;
  import rpmc_pkg::*;

  typedef struct packed {
    logic       oe;
    logic       hpd;
    logic       sd;
    logic       pd;
    logic [5:0] en;
    logic       pdo;
    logic       hpo;
  } rpmc_row_t;

  localparam logic [6:0] ADDR = 7'h2C;  // Arbitrary bus address
  // Pins and power-down bit beside enables {rx,tx,cdr,ddc,aux,bus}
  localparam rpmc_row_t ROWS [6] = '{
    '{1'b1, 1'b1, 1'b1, 1'b0, 6'h3F, 1'b0, 1'b1},
    '{1'b1, 1'b1, 1'b0, 1'b0, 6'h27, 1'b0, 1'b1},
    '{1'b1, 1'b0, 1'b1, 1'b0, 6'h01, 1'b1, 1'b0},
    '{1'b1, 1'b1, 1'b1, 1'b1, 6'h01, 1'b1, 1'b1},
    '{1'b0, 1'b1, 1'b1, 1'b0, 6'h00, 1'b1, 1'b1},
    '{1'b0, 1'b0, 1'b1, 1'b0, 6'h00, 1'b1, 1'b0}};
  localparam logic [7:0]  SENSE [3] = '{8'h55, 8'h00, 8'hAA};
  localparam logic [11:0] S_EXP [3] = '{12'h401, 12'h00C, 12'h807};

  logic       clk;
  logic       rst;
  logic       oe;
  logic       hpd;
  logic       sd;
  logic       smode;
  logic [7:0] sense;
  logic       bus_clk;
  logic       host_low;
  logic       dut_do;
  logic       dut_oe;
  logic       sda_w;
  logic       hpd_out;
  logic       pd_out;
  rpmc_en_t   en;
  rpmc_cfg_t  cfg;
  logic       ok;
  logic [7:0] rd;
  logic [11:0] strap_seen;
  int         errors;
  int         comparisons;

  // Open-drain wire: low if either party pulls, else pull-up
  assign sda_w = ~(host_low | (dut_oe & ~dut_do));

  rpmc_power_mode_control #(.DEV_ADDR(ADDR)) dut_u (
    .sys_clk_in              (clk),
    .reset_in                (rst),
    .output_enable_in        (oe),
    .sink_hotplug_in         (hpd),
    .signal_detect_in        (sd),
    .strap_mode_in           (smode),
    .strap_sense_in          (sense),
    .control_bus_clock_in    (bus_clk),
    .control_bus_data_in     (sda_w),
    .control_bus_data_out    (dut_do),
    .control_bus_data_oe_out (dut_oe),
    .source_hotplug_out      (hpd_out),
    .power_down_out          (pd_out),
    .enables_out             (en),
    .cfg_out                 (cfg)
  );

  rpmc_bus_host #(.DEV_ADDR(ADDR)) host_u (
    .clk_in       (clk),
    .data_in      (sda_w),
    .clock_out    (bus_clk),
    .data_low_out (host_low)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR time=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("Counts: comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Pins pass a synchroniser and filter, so settle well past 4 edges
  task automatic pins(input logic o, input logic h, input logic s);
    @(posedge clk);
    oe  <= o;
    hpd <= h;
    sd  <= s;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] off, input logic [7:0] dat);
    host_u.write_reg(off, dat, ok);
    check(ok, 1'b1);
  endtask

  task automatic rd_chk(input logic [7:0] off, input logic [7:0] exp);
    host_u.read_reg(off, rd, ok);
    check(rd, exp);
  endtask

  // Free-running 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Watchdog sized well above the roughly 23k cycles of bus traffic
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    $display("Watchdog expired at time=%0t", $time);
    stop_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    comparisons = 0;
    rst = 1'b1;
    oe = 1'b0;
    hpd = 1'b0;
    sd = 1'b0;
    smode = 1'b0;
    sense = 8'h00;
    repeat (5) @(posedge clk);
    @(negedge clk);
    check({pd_out, hpd_out, en}, {1'b1, 1'b0, 6'h00});
    @(posedge clk);
    rst <= 1'b0;
    $display("Test reset done");

    // Power state table, power-down bit written only while enabled
    for (int i = 0; i < 6; i++) begin
      pins(ROWS[i].oe, ROWS[i].hpd, ROWS[i].sd);
      if (ROWS[i].oe) wr(REG_POWER, {4'h0, ROWS[i].pd, 3'h0});
      @(negedge clk);
      check(en, ROWS[i].en);
      check(pd_out, ROWS[i].pdo);
      check(hpd_out, ROWS[i].hpo);
    end
    $display("Test power table done");

    // Field placement and readback; bit set before enable drop is gone
    pins(1'b1, 1'b1, 1'b1);
    rd_chk(REG_POWER, RST_POWER);
    wr(REG_TERM, 8'h98);
    wr(REG_SWING, 8'hFD);
    wr(REG_POWER, 8'h03);
    @(negedge clk);
    check(cfg.term, 2'h3);
    check(cfg.slew, SLEW_REC);
    check(cfg.swing, 6'h3F);
    check(cfg.emphasis, 2'h1);
    check({cfg.lane_swap, cfg.retimer}, 2'h3);
    rd_chk(REG_TERM, 8'h98);
    rd_chk(REG_SWING, 8'hFD);
    rd_chk(8'h20, READ_NONE);
    $display("Test registers done");

    // Enable drop: bus refused, then rising edge restores defaults
    pins(1'b0, 1'b1, 1'b1);
    host_u.read_reg(REG_TERM, rd, ok);
    check(ok, 1'b0);
    pins(1'b1, 1'b1, 1'b1);
    check(cfg, 16'h0000);
    rd_chk(REG_TERM, RST_TERM);
    rd_chk(REG_SWING, RST_SWING);
    $display("Test enable reset done");

    // Clock-ratio flag cleared in both power-down kinds
    wr(REG_RATIO, 8'h01);
    rd_chk(REG_RATIO, 8'h01);
    pins(1'b1, 1'b0, 1'b1);
    rd_chk(REG_RATIO, 8'h00);
    pins(1'b1, 1'b1, 1'b1);
    wr(REG_RATIO, 8'h01);
    wr(REG_POWER, 8'h08);
    rd_chk(REG_RATIO, 8'h00);
    wr(REG_POWER, 8'h00);
    $display("Test clock ratio done");

    // Strap decode: all pins low, then mid, then high
    @(posedge clk);
    smode <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      sense <= SENSE[i];
      repeat (8) @(posedge clk);
      @(negedge clk);
      strap_seen = {cfg.emphasis, cfg.swing, cfg.term_auto, cfg.slew, cfg.eq_fixed};
      check(strap_seen, S_EXP[i]);
      if (i != 1) check(cfg.term, (i == 0) ? CODE_ZERO : CODE_MAX);
    end
    $display("Test straps done");
    stop_test();
  end

endmodule
